// file: crc_pkg.sv
// Constants shared by the comparator reference control block
// Functional notes
// - Enable bit 7 powers the ladder
// - Disabled, code 0000, low range: output grounded
// - Four-bit code picks one of 16 levels
// - Bit 4 ignores writes, reads zero
// - Comparator controls: ones at power-on, else kept
// - Status power-on 0001 1xxx, warm reset rules
package crc_pkg;

    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DIR_W  = 6;
    localparam int LVL_W  = 7;

    // Register offsets
    localparam logic [7:0] OFS_STATUS     = 8'h03;
    localparam logic [7:0] OFS_CMP1_SMALL = 8'h07;
    localparam logic [7:0] OFS_CMP1_LARGE = 8'h08;
    localparam logic [7:0] OFS_CMP2       = 8'h0B;
    localparam logic [7:0] OFS_REF        = 8'h0C;
    localparam logic [7:0] OFS_DIR_B      = 8'h10;
    localparam logic [7:0] OFS_DIR_C      = 8'h11;
    localparam logic [7:0] OFS_DIR_GP     = 8'h12;

    // Values after reset
    localparam logic [7:0] STATUS_POR   = 8'h18;
    localparam logic [7:0] CMP_POR      = 8'hFF;
    localparam logic [7:0] REF_RST      = 8'h2F;
    localparam logic [5:0] DIR_RST      = 6'h3F;

    // Reference control fields
    localparam int REF_EN_BIT    = 7;
    localparam int REF_OE_BIT    = 6;
    localparam int REF_RANGE_BIT = 5;
    localparam int REF_CODE_MSB  = 3;
    localparam logic [7:0] REF_WMASK = 8'hEF;

    // Status fields
    localparam int ST_PINWAKE_BIT = 7;
    localparam int ST_CMPWAKE_BIT = 6;
    localparam int ST_PAGE_BIT    = 5;
    localparam int ST_TIMEOUT_BIT = 4;
    localparam int ST_PWRDN_BIT   = 3;
    localparam logic [7:0] ST_SW_WMASK  = 8'h27;
    localparam logic [7:0] ST_LOW_MASK  = 8'h07;

    // Comparator result bit, read live
    localparam int CMP_RESULT_BIT = 7;

    // Ladder level in 96ths of supply
    localparam logic [6:0] LOW_STEP  = 7'h04;
    localparam logic [6:0] HIGH_BASE = 7'h18;
    localparam logic [6:0] HIGH_STEP = 7'h03;

endpackage

// file: crc_ref_if.sv
// Carrier of ladder controls and derived level between top and ladder
`timescale 1ns/1ps
interface crc_ref_if;
    logic       ladder_power_on;
    logic       ref_pin_drive_enable;
    logic       range_select;
    logic [3:0] level_code;
    logic [6:0] internal_reference_level;
    logic       ref_ground_force;
    logic       ref_pin_oe;

    modport ctrl (
        output ladder_power_on,
        output ref_pin_drive_enable,
        output range_select,
        output level_code,
        input  internal_reference_level,
        input  ref_ground_force,
        input  ref_pin_oe
    );

    modport ladder (
        input  ladder_power_on,
        input  ref_pin_drive_enable,
        input  range_select,
        input  level_code,
        output internal_reference_level,
        output ref_ground_force,
        output ref_pin_oe
    );
endinterface

// file: crc_ladder.sv
// Digital model of the reference ladder tap selection
`timescale 1ns/1ps
module crc_ladder (
    crc_ref_if.ladder lad
);

    logic [6:0] tap;

    always_comb begin
        tap = 7'h00;
        if (lad.range_select) begin
            tap = crc_pkg::LOW_STEP * {3'h0, lad.level_code};
        end else begin
            tap = crc_pkg::HIGH_BASE
                + crc_pkg::HIGH_STEP * {3'h0, lad.level_code};
        end
    end

    // Unpowered ladder draws nothing; only the grounded case is defined
    assign lad.internal_reference_level =
        lad.ladder_power_on ? tap : 7'h00;
    assign lad.ref_ground_force = !lad.ladder_power_on
                                && lad.range_select
                                && (lad.level_code == 4'h0);
    assign lad.ref_pin_oe = lad.ref_pin_drive_enable;

endmodule

// file: crc_top.sv
// Register bank for comparator reference, comparator and port controls
`timescale 1ns/1ps
module crc_top (
    // Clock and resets
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       warm_rst,
    input  wire logic [3:0] warm_cause,

    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,

    // Comparator results and wake events
    input  wire logic       first_compare_result,
    input  wire logic       second_compare_result,
    input  wire logic       comparator_wake_evt,
    input  wire logic       pin_change_wake_evt,

    // Controls to the analog ladder
    output logic            ladder_power_on,
    output logic            ref_pin_drive_enable,
    output logic            range_select,
    output logic      [3:0] level_code,
    output logic      [6:0] internal_reference_level,
    output logic            ref_ground_force,
    output logic            ref_pin_oe,

    // Controls to comparators and ports, and status value
    output logic      [7:0] cmp1_small_ctrl,
    output logic      [7:0] cmp1_large_ctrl,
    output logic      [7:0] cmp2_ctrl,
    output logic      [5:0] port_b_dir,
    output logic      [5:0] port_c_dir,
    output logic      [5:0] gp_dir,
    output logic      [7:0] status_value
);

    crc_ref_if ref_bus ();

    // Reset release synchroniser
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Register storage
    logic [7:0] status_flags_ff;
    logic [7:0] comparator1_control_small_ff;
    logic [7:0] comparator1_control_large_ff;
    logic [7:0] comparator2_control_ff;
    logic [5:0] port_b_direction_ff;
    logic [5:0] port_c_direction_ff;
    logic [5:0] general_port_direction_ff;
    logic [7:0] reference_level_control_ff;
    logic [7:0] rdata_ff;

    // Write hits
    logic wr_status;
    logic wr_cmp1_small;
    logic wr_cmp1_large;
    logic wr_cmp2;
    logic wr_ref;
    logic wr_dir_b;
    logic wr_dir_c;
    logic wr_dir_gp;

    always_comb begin
        wr_status     = 1'b0;
        wr_cmp1_small = 1'b0;
        wr_cmp1_large = 1'b0;
        wr_cmp2       = 1'b0;
        wr_ref        = 1'b0;
        wr_dir_b      = 1'b0;
        wr_dir_c      = 1'b0;
        wr_dir_gp     = 1'b0;
        if (!reg_wr) begin
            wr_status = 1'b0;
        end else if (reg_addr == crc_pkg::OFS_STATUS) begin
            wr_status = 1'b1;
        end else if (reg_addr == crc_pkg::OFS_CMP1_SMALL) begin
            wr_cmp1_small = 1'b1;
        end else if (reg_addr == crc_pkg::OFS_CMP1_LARGE) begin
            wr_cmp1_large = 1'b1;
        end else if (reg_addr == crc_pkg::OFS_CMP2) begin
            wr_cmp2 = 1'b1;
        end else if (reg_addr == crc_pkg::OFS_REF) begin
            wr_ref = 1'b1;
        end else if (reg_addr == crc_pkg::OFS_DIR_B) begin
            wr_dir_b = 1'b1;
        end else if (reg_addr == crc_pkg::OFS_DIR_C) begin
            wr_dir_c = 1'b1;
        end else if (reg_addr == crc_pkg::OFS_DIR_GP) begin
            wr_dir_gp = 1'b1;
        end
    end

    // Reference control: same value on every reset
    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            reference_level_control_ff <= crc_pkg::REF_RST;
        end else if (warm_rst) begin
            reference_level_control_ff <= crc_pkg::REF_RST;
        end else if (wr_ref) begin
            reference_level_control_ff <= reg_wdata & crc_pkg::REF_WMASK;
        end
    end

    // Comparator controls: kept across warm reset
    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            comparator1_control_small_ff <= crc_pkg::CMP_POR;
        end else if (wr_cmp1_small && !warm_rst) begin
            comparator1_control_small_ff <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            comparator1_control_large_ff <= crc_pkg::CMP_POR;
        end else if (wr_cmp1_large && !warm_rst) begin
            comparator1_control_large_ff <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            comparator2_control_ff <= crc_pkg::CMP_POR;
        end else if (wr_cmp2 && !warm_rst) begin
            comparator2_control_ff <= reg_wdata;
        end
    end

    // Port directions: all inputs after any reset
    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            port_b_direction_ff <= crc_pkg::DIR_RST;
        end else if (warm_rst) begin
            port_b_direction_ff <= crc_pkg::DIR_RST;
        end else if (wr_dir_b) begin
            port_b_direction_ff <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            port_c_direction_ff <= crc_pkg::DIR_RST;
        end else if (warm_rst) begin
            port_c_direction_ff <= crc_pkg::DIR_RST;
        end else if (wr_dir_c) begin
            port_c_direction_ff <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            general_port_direction_ff <= crc_pkg::DIR_RST;
        end else if (warm_rst) begin
            general_port_direction_ff <= crc_pkg::DIR_RST;
        end else if (wr_dir_gp) begin
            general_port_direction_ff <= reg_wdata[5:0];
        end
    end

    // Status: wake flags set by events, cleared by writing zero
    logic [7:0] nxt_status;
    logic [7:0] st_warm;

    always_comb begin
        st_warm = status_flags_ff & crc_pkg::ST_LOW_MASK;
        st_warm[crc_pkg::ST_PINWAKE_BIT] = warm_cause[3];
        st_warm[crc_pkg::ST_CMPWAKE_BIT] = warm_cause[2];
        st_warm[crc_pkg::ST_TIMEOUT_BIT] = warm_cause[1];
        st_warm[crc_pkg::ST_PWRDN_BIT]   = warm_cause[0];
        nxt_status = status_flags_ff;
        if (wr_status) begin
            nxt_status = (status_flags_ff & ~crc_pkg::ST_SW_WMASK)
                       | (reg_wdata & crc_pkg::ST_SW_WMASK);
            nxt_status[crc_pkg::ST_PINWAKE_BIT] =
                status_flags_ff[crc_pkg::ST_PINWAKE_BIT]
                & reg_wdata[crc_pkg::ST_PINWAKE_BIT];
            nxt_status[crc_pkg::ST_CMPWAKE_BIT] =
                status_flags_ff[crc_pkg::ST_CMPWAKE_BIT]
                & reg_wdata[crc_pkg::ST_CMPWAKE_BIT];
        end
        // Set wins over a clear in the same cycle
        if (pin_change_wake_evt) begin
            nxt_status[crc_pkg::ST_PINWAKE_BIT] = 1'b1;
        end
        if (comparator_wake_evt) begin
            nxt_status[crc_pkg::ST_CMPWAKE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            status_flags_ff <= crc_pkg::STATUS_POR;
        end else if (warm_rst) begin
            status_flags_ff <= st_warm;
        end else begin
            status_flags_ff <= nxt_status;
        end
    end

    // Read path: data valid only in the cycle after the strobe
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == crc_pkg::OFS_STATUS) begin
            rd_mux = status_flags_ff;
        end else if (reg_addr == crc_pkg::OFS_CMP1_SMALL) begin
            rd_mux = comparator1_control_small_ff;
            rd_mux[crc_pkg::CMP_RESULT_BIT] = first_compare_result;
        end else if (reg_addr == crc_pkg::OFS_CMP1_LARGE) begin
            rd_mux = comparator1_control_large_ff;
            rd_mux[crc_pkg::CMP_RESULT_BIT] = first_compare_result;
        end else if (reg_addr == crc_pkg::OFS_CMP2) begin
            rd_mux = comparator2_control_ff;
            rd_mux[crc_pkg::CMP_RESULT_BIT] = second_compare_result;
        end else if (reg_addr == crc_pkg::OFS_REF) begin
            rd_mux = reference_level_control_ff & crc_pkg::REF_WMASK;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;

    // Ladder controls straight from the register bits
    assign ref_bus.ladder_power_on =
        reference_level_control_ff[crc_pkg::REF_EN_BIT];
    assign ref_bus.ref_pin_drive_enable =
        reference_level_control_ff[crc_pkg::REF_OE_BIT];
    assign ref_bus.range_select =
        reference_level_control_ff[crc_pkg::REF_RANGE_BIT];
    assign ref_bus.level_code =
        reference_level_control_ff[crc_pkg::REF_CODE_MSB:0];

    crc_ladder u_ladder (
        .lad (ref_bus.ladder)
    );

    assign ladder_power_on          = ref_bus.ladder_power_on;
    assign ref_pin_drive_enable     = ref_bus.ref_pin_drive_enable;
    assign range_select             = ref_bus.range_select;
    assign level_code               = ref_bus.level_code;
    assign internal_reference_level = ref_bus.internal_reference_level;
    assign ref_ground_force         = ref_bus.ref_ground_force;
    assign ref_pin_oe               = ref_bus.ref_pin_oe;

    assign cmp1_small_ctrl = comparator1_control_small_ff;
    assign cmp1_large_ctrl = comparator1_control_large_ff;
    assign cmp2_ctrl       = comparator2_control_ff;
    assign port_b_dir      = port_b_direction_ff;
    assign port_c_dir      = port_c_direction_ff;
    assign gp_dir          = general_port_direction_ff;
    assign status_value    = status_flags_ff;

endmodule

// file: crc_top_checker.sv
// Assertion checker for the comparator reference register bank
`timescale 1ns/1ps
module crc_top_checker (
    // Clock and resets
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       warm_rst,
    input wire logic [3:0] warm_cause,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Wake events
    input wire logic       comparator_wake_evt,
    input wire logic       pin_change_wake_evt,
    // Ladder and register outputs
    input wire logic       ladder_power_on,
    input wire logic       ref_pin_drive_enable,
    input wire logic       range_select,
    input wire logic [3:0] level_code,
    input wire logic [6:0] internal_reference_level,
    input wire logic       ref_ground_force,
    input wire logic       ref_pin_oe,
    input wire logic [7:0] cmp1_small_ctrl,
    input wire logic [7:0] cmp2_ctrl,
    input wire logic [7:0] status_value
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence ref_wr_s;
        reg_wr && !warm_rst && reg_addr == crc_pkg::OFS_REF;
    endsequence
    sequence ref_rd_s;
        reg_rd && reg_addr == crc_pkg::OFS_REF;
    endsequence
    sequence warm_s;
        warm_rst && !comparator_wake_evt && !pin_change_wake_evt;
    endsequence

    ctrl_follow_a: assert property (
        ref_wr_s |=> {ladder_power_on, ref_pin_drive_enable, range_select,
            level_code} == {$past(reg_wdata[7:5]), $past(reg_wdata[3:0])})
        else $error("ladder controls did not follow write");
    level_low_a: assert property (
        ladder_power_on && range_select |->
            internal_reference_level == {1'b0, level_code, 2'b00})
        else $error("low range level wrong");
    level_high_a: assert property (
        ladder_power_on && !range_select |-> internal_reference_level ==
            7'h18 + {3'h0, level_code} * 7'h03)
        else $error("high range level wrong");
    ground_force_a: assert property (
        ref_ground_force == (!ladder_power_on && range_select &&
            level_code == 4'h0))
        else $error("ground force wrong");
    pin_drive_a: assert property (
        ref_pin_oe == ref_pin_drive_enable)
        else $error("pin enable differs from drive bit");
    bit4_zero_a: assert property (
        ref_rd_s |=> !reg_rdata[4])
        else $error("unused bit read as one");
    cmp_keep_a: assert property (
        warm_rst |=> $stable(cmp1_small_ctrl) && $stable(cmp2_ctrl))
        else $error("comparator control changed on warm reset");
    status_warm_a: assert property (
        warm_s |=> status_value == {$past(warm_cause[3:2]), 1'b0,
            $past(warm_cause[1:0]), $past(status_value[2:0])})
        else $error("status wrong after warm reset");
endmodule

bind crc_top crc_top_checker chk_u (
    .core_clk, .rst_b, .warm_rst, .warm_cause, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .comparator_wake_evt,
    .pin_change_wake_evt, .ladder_power_on, .ref_pin_drive_enable,
    .range_select, .level_code, .internal_reference_level,
    .ref_ground_force, .ref_pin_oe, .cmp1_small_ctrl, .cmp2_ctrl,
    .status_value
);

// file: tb_top.sv
// Self-checking bench for the comparator reference register bank
`timescale 1ns/1ps
module tb_top;
    logic       core_clk, rst_b, warm_rst, reg_wr, reg_rd;
    logic [3:0] warm_cause, level_code;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, status_value, d;
    logic       first_compare_result, second_compare_result;
    logic       comparator_wake_evt, pin_change_wake_evt;
    logic       ladder_power_on, ref_pin_drive_enable, range_select;
    logic [6:0] internal_reference_level;
    logic       ref_ground_force, ref_pin_oe;
    logic [7:0] cmp1_small_ctrl, cmp1_large_ctrl, cmp2_ctrl;
    logic [5:0] port_b_dir, port_c_dir, gp_dir;
    logic [7:0] lad_v;
    int         fails, tests_run, cycles;

    assign lad_v = {ladder_power_on, ref_pin_drive_enable, range_select,
                    1'b0, level_code};

    crc_top dut_u (
        .core_clk, .rst_b, .warm_rst, .warm_cause, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .first_compare_result,
        .second_compare_result, .comparator_wake_evt, .pin_change_wake_evt,
        .ladder_power_on, .ref_pin_drive_enable, .range_select, .level_code,
        .internal_reference_level, .ref_ground_force, .ref_pin_oe,
        .cmp1_small_ctrl, .cmp1_large_ctrl, .cmp2_ctrl, .port_b_dir,
        .port_c_dir, .gp_dir, .status_value
    );

    task automatic close_out;
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask

    task automatic por;
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        rst_b = 1'b0;
        warm_rst = 1'b0;
        warm_cause = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        first_compare_result = 1'b0;
        second_compare_result = 1'b1;
        comparator_wake_evt = 1'b0;
        pin_change_wake_evt = 1'b0;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        por();
        chk("cmp1_small_ctrl", 8'hFF, cmp1_small_ctrl);
        chk("cmp2_ctrl", 8'hFF, cmp2_ctrl);
        chk("cmp1_large_ctrl", 8'hFF, cmp1_large_ctrl);
        chk("status_value", 8'h18, status_value);
        chk("port_b_dir", 8'h3F, {2'h0, port_b_dir});
        chk("port_c_dir", 8'h3F, {2'h0, port_c_dir});
        chk("gp_dir", 8'h3F, {2'h0, gp_dir});
        chk("ladder ctrl", 8'h2F, lad_v);
        rd(crc_pkg::OFS_CMP1_SMALL, 8'h7F);
        rd(crc_pkg::OFS_CMP2, 8'hFF);
        rd(crc_pkg::OFS_REF, 8'h2F);
        // Every code in both ranges, bit 4 written as one
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 16; c++) begin
                d = {2'b10, r[0], 1'b1, c[3:0]};
                wr(crc_pkg::OFS_REF, d);
                chk("ladder ctrl", d & 8'hEF, lad_v);
                chk("level", r ? 8'(c * 4) : 8'(24 + c * 3),
                    {1'b0, internal_reference_level});
                rd(crc_pkg::OFS_REF, d & 8'hEF);
            end
        end
        wr(crc_pkg::OFS_REF, 8'hC0);
        chk("ref_pin_oe", 8'h01, {7'h00, ref_pin_oe});
        wr(crc_pkg::OFS_REF, 8'h80);
        chk("ref_pin_oe", 8'h00, {7'h00, ref_pin_oe});
        wr(crc_pkg::OFS_REF, 8'h20);
        chk("ladder ctrl", 8'h20, lad_v);
        chk("ground", 8'h01, {7'h00, ref_ground_force});
        wr(crc_pkg::OFS_REF, 8'h21);
        chk("ground", 8'h00, {7'h00, ref_ground_force});
        wr(crc_pkg::OFS_REF, 8'hA0);
        chk("ground", 8'h00, {7'h00, ref_ground_force});
        rd(8'h40, 8'h00);
        wr(crc_pkg::OFS_DIR_B, 8'h15);
        chk("port_b_dir", 8'h15, {2'h0, port_b_dir});
        rd(crc_pkg::OFS_DIR_B, 8'h00);
        wr(crc_pkg::OFS_DIR_C, 8'h2A);
        chk("port_c_dir", 8'h2A, {2'h0, port_c_dir});
        wr(crc_pkg::OFS_DIR_GP, 8'h09);
        chk("gp_dir", 8'h09, {2'h0, gp_dir});
        // Warm reset keeps comparator controls, rebuilds status
        wr(crc_pkg::OFS_CMP1_LARGE, 8'h6C);
        wr(crc_pkg::OFS_CMP1_SMALL, 8'hDA);
        wr(crc_pkg::OFS_CMP2, 8'hB3);
        wr(crc_pkg::OFS_STATUS, 8'h25);
        chk("status_value", 8'h3D, status_value);
        wr(crc_pkg::OFS_REF, 8'hC3);
        @(posedge core_clk);
        warm_rst   <= 1'b1;
        warm_cause <= 4'hA;
        @(posedge core_clk);
        warm_rst <= 1'b0;
        #1;
        chk("status_value", 8'h95, status_value);
        chk("cmp1_small_ctrl", 8'hDA, cmp1_small_ctrl);
        chk("cmp2_ctrl", 8'hB3, cmp2_ctrl);
        chk("ladder ctrl", 8'h2F, lad_v);
        chk("port_b_dir", 8'h3F, {2'h0, port_b_dir});
        chk("port_c_dir", 8'h3F, {2'h0, port_c_dir});
        chk("gp_dir", 8'h3F, {2'h0, gp_dir});
        chk("cmp1_large_ctrl", 8'h6C, cmp1_large_ctrl);
        rd(crc_pkg::OFS_CMP1_SMALL, 8'h5A);
        @(posedge core_clk);
        first_compare_result <= 1'b1;
        rd(crc_pkg::OFS_CMP1_LARGE, 8'hEC);
        @(posedge core_clk);
        comparator_wake_evt <= 1'b1;
        @(posedge core_clk);
        comparator_wake_evt <= 1'b0;
        #1;
        chk("status_value", 8'hD5, status_value);
        wr(crc_pkg::OFS_STATUS, 8'h00);
        chk("status_value", 8'h10, status_value);
        // Wake event beside a clearing write: the set wins
        @(posedge core_clk);
        reg_wr              <= 1'b1;
        reg_addr            <= crc_pkg::OFS_STATUS;
        reg_wdata           <= 8'h00;
        pin_change_wake_evt <= 1'b1;
        @(posedge core_clk);
        reg_wr              <= 1'b0;
        pin_change_wake_evt <= 1'b0;
        #1;
        chk("status_value", 8'h90, status_value);
        // Power-on reset in mid-run restores everything
        por();
        chk("cmp1_small_ctrl", 8'hFF, cmp1_small_ctrl);
        chk("cmp1_large_ctrl", 8'hFF, cmp1_large_ctrl);
        chk("ladder ctrl", 8'h2F, lad_v);
        chk("status_value", 8'h18, status_value);
        close_out();
    end
endmodule
